// ---- bus_condition.sv ----
// START and STOP detection and frame reset for the link logic
module bus_condition (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic scl_s,
  input  wire logic sda_s,
  output logic      start_p,
  output logic      stop_p,
  output logic      link_rst
);

  logic sda_prev_q;
  logic armed_q;

  // SDA moving while SCL is high is a condition, never data
  assign start_p = scl_s && sda_prev_q && !sda_s; // R3 R4
  assign stop_p  = scl_s && !sda_prev_q && sda_s; // R3 R5

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sda_prev_q <= 1'b1;
    end else begin
      sda_prev_q <= sda_s;
    end
  end

  // Link held in reset from STOP until a START, released once SCL is low
  // so the release never lands near a rising SCL edge
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      link_rst <= 1'b1;
      armed_q  <= 1'b0;
    end else if (start_p) begin
      link_rst <= 1'b1;
      armed_q  <= 1'b1;
    end else if (stop_p) begin
      link_rst <= 1'b1; // R5
      armed_q  <= 1'b0;
    end else if (armed_q && !scl_s) begin
      link_rst <= 1'b0;
      armed_q  <= 1'b0;
    end
  end

  chk_stop_holds_link: assert property (@(posedge clock) disable iff (sys_rst) // R5
    stop_p |=> link_rst && !armed_q)
    else $error("link not held after stop");

  chk_start_arms_link: assert property (@(posedge clock) disable iff (sys_rst) // R4
    start_p |=> link_rst && armed_q)
    else $error("start did not arm link release");

endmodule : bus_condition

// ---- level_sync.sv ----
// Two-flop level synchroniser into the system clock domain
module level_sync #(
  parameter int unsigned      WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_d,
  output logic      [WIDTH-1:0] sync_q
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage; reset to the idle level so
  // no false edge is seen when reset lifts
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= RESET_VALUE;
      sync_q <= RESET_VALUE;
    end else begin
      meta_q <= async_d;
      sync_q <= meta_q;
    end
  end

endmodule : level_sync

// ---- rtc_port_pkg.sv ----
// Shared constants and types for the two-wire RTC slave port
package rtc_port_pkg;

  // Slave address byte with the direction bit clear
  localparam logic [7:0] SLAVE_ADDR_BYTE = 8'hD0;

  // Register file size and notable pointer values
  localparam int unsigned REG_COUNT       = 8;
  localparam logic [2:0]  PTR_RESET       = 3'h0;
  localparam logic [2:0]  LAST_CLOCK_ADDR = 3'h6;
  localparam logic [2:0]  CAL_ADDR        = 3'h7;
  localparam logic [7:0]  REG_RESET       = 8'h00;

  // Idle level of the sampled SCL and SDA pins, both pulled high
  localparam logic [1:0]  PIN_IDLE        = 2'h3;

  // Bit counter positions inside one nine-clock byte slot
  localparam logic [3:0]  FIRST_BIT = 4'h0;
  localparam logic [3:0]  LAST_BIT  = 4'h7;
  localparam logic [3:0]  ACK_SLOT  = 4'h8;

  // Transfer phase of the link engine
  typedef enum logic [2:0] {
    PH_ADDR   = 3'b000,
    PH_WORD   = 3'b001,
    PH_WDATA  = 3'b010,
    PH_RDATA  = 3'b011,
    PH_IGNORE = 3'b100,
    PH_NACKED = 3'b101
  } link_phase_t;

endpackage : rtc_port_pkg

// ---- rtc_two_wire_slave_port.sv ----
// Two-wire slave port of the real-time clock with pointer and register shadow
// Functional notes
// R1: Respond only to START followed by slave address D0h.
// R2: Eight bytes in sequence: seconds to years, then calibration.
// R3: SDA stable while SCL high; changes then are conditions.
// R4: SDA falling while SCL high is START.
// R5: SDA rising while SCL high is STOP.
// R6: Master starts only with SDA and SCL both high.
// R7: Transmitter changes SDA only while SCL low; one pulse per bit.
// R8: Eight-bit bytes plus master-clocked ninth acknowledge bit, unlimited count.
// R9: Addressed receiver acknowledges every byte received.
// R10: Master receiver acknowledges all bytes except the last.
// R11: On master no-acknowledge, release SDA for the STOP.
// R12: Acknowledger holds SDA low through the acknowledge clock high.
// R13: Addressed read: write word address, repeated START, read direction.
// R14: Advance pointer only on master acknowledge, then send next byte.
// R15: Keep sending consecutive bytes until STOP.
// R16: Freeze time copy while reading 0h-6h; resume on STOP or 7h.
// R17: Read without word address starts at current pointer.
// R18: Write loads pointer, stores data, advances at acknowledge clock.
// R19: Write acknowledges slave address, word address and every data byte.
// R20: Write to 0h-6h loads counters and resets divider chain.
// R21: Foreign slave address: keep SDA released, ignore transfer.
// R22: Pointer wraps from 7h to 0h.
module rtc_two_wire_slave_port
  import rtc_port_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        scl_clk,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic [55:0] core_time,
  output logic             hold_update,
  output logic             time_load,
  output logic [2:0]       time_load_addr,
  output logic [7:0]       time_load_data,
  output logic [7:0]       cal_value
);

  // System-domain state
  logic [1:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        start_p;
  logic        stop_p;
  logic        link_rst;
  logic        hold_s;
  logic        wr_tgl_s;
  logic        wr_seen_q;
  logic        wr_event;
  logic [7:0]  regs_q [REG_COUNT];
  logic        time_load_q;
  logic [2:0]  time_load_addr_q;
  logic [7:0]  time_load_data_q;

  // Link-domain state
  logic [3:0]  cnt_q;
  logic [7:0]  shift_q;
  link_phase_t phase_q;
  link_phase_t phase_d;
  logic        hdr_q;
  logic        hdr_d;
  logic        freeze_q;
  logic        freeze_d;
  logic [2:0]  ptr_q;
  logic [2:0]  wr_addr_q;
  logic [7:0]  wr_data_q;
  logic        wr_tgl_q;
  logic        sda_oe_q;
  logic [7:0]  tx_q;

  // Link-domain decode
  wire [7:0] rx_byte     = {shift_q[6:0], sda_i};
  wire       byte_end    = (cnt_q == LAST_BIT);
  wire       ack_slot    = (cnt_q == ACK_SLOT);
  wire       addr_hit    = (rx_byte[7:1] == SLAVE_ADDR_BYTE[7:1]);
  wire       data_ack    = ack_slot && !hdr_q;
  wire       master_ack  = data_ack && (phase_q == PH_RDATA) && !sda_i;
  wire       master_nack = data_ack && (phase_q == PH_RDATA) && sda_i;
  wire       ptr_load    = byte_end && (phase_q == PH_WORD);
  wire       ptr_step    = master_ack || (data_ack && (phase_q == PH_WDATA));
  wire       wr_fire     = byte_end && (phase_q == PH_WDATA);
  wire [2:0] ptr_next    = ptr_q + 3'h1;
  wire       ack_me      = ack_slot && ((phase_q == PH_WORD) || (phase_q == PH_WDATA) ||
                                        ((phase_q == PH_RDATA) && hdr_q));
  wire       tx_start    = (cnt_q == FIRST_BIT) && (phase_q == PH_RDATA);
  wire       tx_shift    = (phase_q == PH_RDATA) && !tx_start && !ack_slot;
  // Read path crosses domains; contents held stable by the freeze handshake
  wire [7:0] rd_byte     = regs_q[ptr_q];

  assign sda_o          = 1'b0;
  assign sda_oe         = sda_oe_q;
  assign hold_update    = hold_s;
  assign time_load      = time_load_q;
  assign time_load_addr = time_load_addr_q;
  assign time_load_data = time_load_data_q;
  assign cal_value      = regs_q[CAL_ADDR];

  // Pin sampling for condition detection; idles high like the bus
  level_sync #(.WIDTH(2), .RESET_VALUE(PIN_IDLE)) u_pin_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .async_d ({scl_clk, sda_i}),
    .sync_q  (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  bus_condition u_cond (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .scl_s    (scl_s),
    .sda_s    (sda_s),
    .start_p  (start_p),
    .stop_p   (stop_p),
    .link_rst (link_rst)
  );

  // Next phase, header flag and freeze level of the link engine
  always_comb begin
    phase_d  = phase_q;
    hdr_d    = ack_slot ? 1'b0 : hdr_q;
    freeze_d = freeze_q;
    if (byte_end) begin
      unique case (phase_q)
        PH_ADDR: begin
          hdr_d    = 1'b1;
          phase_d  = !addr_hit ? PH_IGNORE : (rx_byte[0] ? PH_RDATA : PH_WORD); // R1 R13 R21
          freeze_d = addr_hit && rx_byte[0] && (ptr_q != CAL_ADDR); // R16 R17
        end
        PH_WORD: begin
          hdr_d   = 1'b1;
          phase_d = PH_WDATA;
        end
        PH_WDATA, PH_RDATA, PH_IGNORE, PH_NACKED: begin
          phase_d = phase_q;
        end
        default: begin
          phase_d = PH_IGNORE;
        end
      endcase
    end
    if (master_nack) begin
      phase_d = PH_NACKED; // R11
    end
    if (master_ack) begin
      freeze_d = (ptr_next != CAL_ADDR); // R16
    end
  end

  // Bit sampling on the rising SCL edge; one edge per bit, ninth is acknowledge
  always_ff @(posedge scl_clk or posedge link_rst) begin
    if (link_rst) begin
      cnt_q    <= FIRST_BIT;
      shift_q  <= REG_RESET;
      phase_q  <= PH_ADDR;
      hdr_q    <= 1'b0;
      freeze_q <= 1'b0;
    end else begin
      cnt_q    <= ack_slot ? FIRST_BIT : cnt_q + 4'h1; // R7 R8
      shift_q  <= ack_slot ? shift_q : rx_byte;
      phase_q  <= phase_d;
      hdr_q    <= hdr_d;
      freeze_q <= freeze_d;
    end
  end

  // Pointer survives frames so a bare read starts where the last one stopped
  always_ff @(posedge scl_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_q <= PTR_RESET;
    end else if (ptr_load) begin
      ptr_q <= rx_byte[2:0]; // R13 R18
    end else if (ptr_step) begin
      ptr_q <= ptr_next; // R14 R18 R22
    end
  end

  // Write word held for the system domain; toggle announces it
  always_ff @(posedge scl_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_addr_q <= PTR_RESET;
      wr_data_q <= REG_RESET;
      wr_tgl_q  <= 1'b0;
    end else if (wr_fire) begin
      wr_addr_q <= ptr_q; // R18
      wr_data_q <= rx_byte;
      wr_tgl_q  <= !wr_tgl_q;
    end
  end

  // SDA driven only after falling SCL, so it is steady while SCL is high
  always_ff @(negedge scl_clk or posedge link_rst) begin
    if (link_rst) begin
      sda_oe_q <= 1'b0;
      tx_q     <= REG_RESET;
    end else if (ack_me) begin
      sda_oe_q <= 1'b1; // R9 R12 R19
    end else if (tx_start) begin
      sda_oe_q <= !rd_byte[7]; // R7 R15 R17
      tx_q     <= {rd_byte[6:0], 1'b0};
    end else if (tx_shift) begin
      sda_oe_q <= !tx_q[7]; // R7
      tx_q     <= {tx_q[6:0], 1'b0};
    end else begin
      sda_oe_q <= 1'b0; // R11 R21
    end
  end

  // Freeze level and write toggle into the system clock
  level_sync #(.WIDTH(2)) u_ctl_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .async_d ({freeze_q, wr_tgl_q}),
    .sync_q  ({hold_s, wr_tgl_s})
  );

  assign wr_event = wr_tgl_s ^ wr_seen_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_seen_q <= 1'b0;
    end else begin
      wr_seen_q <= wr_tgl_s;
    end
  end

  // Register shadow: clock bytes track the core unless frozen, calibration is stored here
  genvar i;
  for (i = 0; i < REG_COUNT; i++) begin : g_reg
    wire hit = wr_event && (wr_addr_q == 3'(i));
    if (i == REG_COUNT - 1) begin : g_cal
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          regs_q[i] <= REG_RESET;
        end else if (hit) begin
          regs_q[i] <= wr_data_q; // R2
        end
      end
    end else begin : g_time
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          regs_q[i] <= REG_RESET;
        end else if (hit) begin
          regs_q[i] <= wr_data_q;
        end else if (!hold_s) begin
          regs_q[i] <= core_time[i*8 +: 8]; // R16
        end
      end
    end
  end

  // Clock-byte writes load the counters and restart the divider chain
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      time_load_q      <= 1'b0;
      time_load_addr_q <= PTR_RESET;
      time_load_data_q <= REG_RESET;
    end else begin
      time_load_q <= wr_event && (wr_addr_q <= LAST_CLOCK_ADDR); // R20
      if (wr_event) begin
        time_load_addr_q <= wr_addr_q;
        time_load_data_q <= wr_data_q;
      end
    end
  end

  // Link-domain checks
  chk_addr_mismatch_ignored: assert property (@(posedge scl_clk) disable iff (link_rst) // R21
    (phase_q == PH_ADDR && byte_end && !addr_hit) |=> ((phase_q == PH_IGNORE) && !sda_oe_q) [*2])
    else $error("foreign address not ignored");

  chk_recv_ack_low: assert property (@(posedge scl_clk) disable iff (link_rst) // R19
    (ack_slot && (phase_q == PH_WORD || phase_q == PH_WDATA)) |-> sda_oe_q)
    else $error("received byte not acknowledged");

  chk_addr_read_ack: assert property (@(posedge scl_clk) disable iff (link_rst) // R9
    (phase_q == PH_ADDR && byte_end && addr_hit) |=> sda_oe_q && ack_slot)
    else $error("address byte not acknowledged");

  chk_nack_releases: assert property (@(posedge scl_clk) disable iff (link_rst) // R11
    master_nack |=> (phase_q == PH_NACKED) && !sda_oe_q)
    else $error("sda held after master nack");

  chk_ptr_on_ack: assert property (@(posedge scl_clk) disable iff (link_rst) // R14
    (ack_slot && phase_q == PH_RDATA && !hdr_q) |=> (ptr_q == ($past(sda_i) ? $past(ptr_q) : $past(ptr_next))))
    else $error("pointer step not tied to master ack");

  chk_ptr_wraps: assert property (@(posedge scl_clk) disable iff (link_rst) // R22
    (ptr_step && ptr_q == CAL_ADDR) |=> ptr_q == PTR_RESET)
    else $error("pointer did not wrap");

  chk_word_loads_ptr: assert property (@(posedge scl_clk) disable iff (link_rst) // R18
    ptr_load |=> ptr_q == $past(rx_byte[2:0]) && wr_addr_q == $past(wr_addr_q))
    else $error("word address not loaded");

  chk_freeze_leaves_cal: assert property (@(posedge scl_clk) disable iff (link_rst) // R16
    (master_ack && ptr_q == LAST_CLOCK_ADDR) |=> !freeze_q && ptr_q == CAL_ADDR)
    else $error("freeze not released at calibration byte");

  // System-domain checks
  chk_hold_keeps_time: assert property (@(posedge clock) disable iff (sys_rst) // R16
    (hold_s && $past(hold_s) && !$past(wr_event)) |-> $stable(regs_q[0]) && $stable(regs_q[6]))
    else $error("time copy moved while frozen");

  chk_clock_write_loads: assert property (@(posedge clock) disable iff (sys_rst) // R20
    wr_event |=> (time_load_q == (time_load_addr_q != CAL_ADDR)) && time_load_data_q == $past(wr_data_q))
    else $error("clock write did not load counters");

  cov_write_byte: cover property (@(posedge scl_clk) disable iff (link_rst) wr_fire);
  cov_read_acked: cover property (@(posedge scl_clk) disable iff (link_rst) master_ack ##9 master_ack);
  cov_read_nacked: cover property (@(posedge scl_clk) disable iff (link_rst) master_nack);
  cov_foreign_addr: cover property (@(posedge scl_clk) disable iff (link_rst) phase_q == PH_IGNORE);

endmodule : rtc_two_wire_slave_port

// ---- tb.sv ----
// Self-checking bench for the two-wire RTC slave port
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rtc_port_pkg::*;

  logic        clock = 1'b0;
  logic        sys_rst;
  logic        scl_clk;
  logic        sda_low;
  wire logic   sda;
  logic        sda_o;
  logic        sda_oe;
  logic [55:0] core_time;
  logic        hold_update;
  logic        time_load;
  logic [2:0]  time_load_addr;
  logic [7:0]  time_load_data;
  logic [7:0]  cal_value;
  int          miscompares = 0;
  int          checks = 0;
  int          cycles = 0;
  int          loads = 0;

  // Open-drain wire with pull-up: low when either party pulls
  assign sda = ~(sda_low | (sda_oe & ~sda_o));

  always #4 clock = ~clock;

  rtc_two_wire_slave_port uut (
    .clock          (clock),
    .sys_rst        (sys_rst),
    .scl_clk        (scl_clk),
    .sda_i          (sda),
    .sda_o          (sda_o),
    .sda_oe         (sda_oe),
    .core_time      (core_time),
    .hold_update    (hold_update),
    .time_load      (time_load),
    .time_load_addr (time_load_addr),
    .time_load_data (time_load_data),
    .cal_value      (cal_value)
  );

  two_wire_master master (
    .scl     (scl_clk),
    .sda_low (sda_low),
    .sda     (sda)
  );

  // Load pulses counted and a hang cut short
  always @(posedge clock) begin
    cycles++;
    if (time_load === 1'b1) begin
      loads++;
    end
    if (cycles == 6000) begin
      miscompares++;
      close_out;
    end
  end

  task automatic close_out;
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Writes: counters at 2 and 3, then calibration and wrap to 0
  task automatic run_write;
    logic a;
    master.bus_start;
    master.write_byte(8'hD0, a);
    cmp({7'h00, a}, 8'h00);
    master.write_byte(8'h02, a);
    cmp({7'h00, a}, 8'h00);
    master.write_byte(8'hA5, a);
    cmp({7'h00, a}, 8'h00);
    master.write_byte(8'h3C, a);
    cmp({7'h00, a}, 8'h00);
    master.bus_stop;
    cmp({5'h00, time_load_addr}, 8'h03);
    cmp(time_load_data, 8'h3C);
    cmp(loads[7:0], 8'h02);
    // Upper word-address bits are ignored, so F7 selects calibration
    master.bus_start;
    master.write_byte(8'hD0, a);
    master.write_byte(8'hF7, a);
    master.write_byte(8'h5A, a);
    cmp({7'h00, a}, 8'h00);
    master.write_byte(8'h11, a);
    master.bus_stop;
    cmp(cal_value, 8'h5A);
    cmp({5'h00, time_load_addr}, 8'h00);
    cmp(time_load_data, 8'h11);
    cmp(loads[7:0], 8'h03);
  endtask : run_write

  // Addressed read from 5 across the wrap, with a frozen copy
  task automatic run_read;
    logic       a;
    logic [7:0] d;
    master.bus_start;
    master.write_byte(8'hD0, a);
    master.write_byte(8'h05, a);
    master.bus_start;
    master.write_byte(8'hD1, a);
    cmp({7'h00, a}, 8'h00);
    master.read_byte(1'b1, d);
    cmp(d, 8'h15);
    cmp({7'h00, hold_update}, 8'h01);
    @(posedge clock) core_time <= 56'h77151413121110;
    master.read_byte(1'b1, d);
    cmp(d, 8'h16);
    cmp({7'h00, hold_update}, 8'h00);
    master.read_byte(1'b1, d);
    cmp(d, 8'h5A);
    master.read_byte(1'b1, d);
    cmp(d, 8'h10);
    master.read_byte(1'b0, d);
    cmp(d, 8'h11);
    cmp({7'h00, sda}, 8'h01);
    master.bus_stop;
    cmp({7'h00, hold_update}, 8'h00);
  endtask : run_read

  // Read with no word address resumes at the unacknowledged byte
  task automatic run_alt_read;
    logic       a;
    logic [7:0] d;
    master.bus_start;
    master.write_byte(8'hD1, a);
    cmp({7'h00, a}, 8'h00);
    master.read_byte(1'b1, d);
    cmp(d, 8'h11);
    master.read_byte(1'b0, d);
    cmp(d, 8'h12);
    master.bus_stop;
  endtask : run_alt_read

  // Foreign address: no acknowledge and no side effect
  task automatic run_foreign;
    logic a;
    master.bus_start;
    master.write_byte(8'hA0, a);
    cmp({7'h00, a}, 8'h01);
    master.write_byte(8'h00, a);
    cmp({7'h00, a}, 8'h01);
    master.bus_stop;
    cmp(loads[7:0], 8'h03);
  endtask : run_foreign

  // Reset, then the scenarios in order
  initial begin
    sys_rst   = 1'b1;
    core_time = 56'h16151413121110;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clock);
    #3;
    run_write;
    run_read;
    run_alt_read;
    run_foreign;
    close_out;
  end
endmodule : tb

// ---- two_wire_master.sv ----
// Behavioural two-wire bus master that clocks the slave port
module two_wire_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus: both lines high, clock stands still between frames
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // START; also serves as repeated START from clock low
  task automatic bus_start;
    sda_low = 1'b0;
    #20 scl = 1'b1;
    #40 sda_low = 1'b1;
    #40 scl = 1'b0;
    #20;
  endtask : bus_start

  // STOP; leaves the bus idle
  task automatic bus_stop;
    sda_low = 1'b1;
    #20 scl = 1'b1;
    #40 sda_low = 1'b0;
    #40;
  endtask : bus_stop

  // One bit slot; sampled twice so a wobble while high shows as a one
  task automatic clk_bit(input logic drive, output logic s);
    sda_low = ~drive;
    #20 scl = 1'b1;
    #10 s = sda;
    #20 s = s | sda;
    #10 scl = 1'b0;
    #20;
  endtask : clk_bit

  // Byte out MSB first, then the ninth clock for the slave's answer
  task automatic write_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], ack);
    end
    clk_bit(1'b1, ack);
  endtask : write_byte

  // Byte in; ack_out low leaves the last byte unacknowledged
  task automatic read_byte(input logic ack_out, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(~ack_out, s);
  endtask : read_byte
endmodule : two_wire_master
